// >>> rtl/core_regs_pkg.sv
// package: offsets, field positions, reset values and shared carriers of the core registers
package core_regs_pkg;

  // register indices on the plain port (byte offsets of the data map)
  localparam logic [7:0] ALU_FLAGS_BANK_SELECT_OFF = 8'h03;
  localparam logic [7:0] ALU_FLAGS_BANK_SELECT_MIR = 8'h83;
  localparam logic [7:0] PRESCALE_TIMER_CONFIG_OFF = 8'h81;

  // status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_BANK_LO = 5;
  localparam int ST_BANK_HI = 6;
  localparam int ST_IND_PAGE = 7;

  // option field positions
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_OWNER = 3;
  localparam int OPT_TMR_EDGE = 4;
  localparam int OPT_TMR_SRC = 5;
  localparam int OPT_IRQ_EDGE = 6;
  localparam int OPT_PULLUP_DIS = 7;

  // values after reset; unknown arithmetic flags are cleared, option all ones
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] OPTION_RESET = 8'hff;

  // bank geometry
  localparam logic [8:0] BANK_SPAN = 9'h080;
  localparam logic [8:0] IND_PAGE_BASE = 9'h100;

  // alu operation class driving the flag logic
  typedef enum logic [1:0] {ALU_NONE, ALU_LOGIC, ALU_ADDSUB, ALU_ROTATE} alu_class_t;

  // one alu flag update from the core
  typedef struct packed {
    logic valid;
    alu_class_t op;
    logic is_sub;
    logic rot_left;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] result;
  } alu_update_t;

  // decoded option controls handed to timer, watchdog and port logic
  typedef struct packed {
    logic pullup_disable;
    logic irq_rising;
    logic timer_external;
    logic timer_falling;
    logic owner_watchdog;
    logic [8:0] timer_div;
    logic [7:0] watchdog_div;
  } option_ctl_t;

endpackage

// >>> rtl/alu_flag_calc.sv
// alu flag calculator: zero, nibble overflow and msb overflow from one operation
`timescale 1ns/100ps
`default_nettype none
module alu_flag_calc
(
  input wire core_regs_pkg::alu_update_t upd,
  output logic zero_flag,
  output logic nibble_flag,
  output logic carry_flag,
  output logic upd_nibble,
  output logic upd_carry
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] b_eff;

  // subtract is add of the two's complement, so carry reads as inverted borrow
  always_comb
  begin
    b_eff = upd.is_sub ? ~upd.b : upd.b;
    sum = {1'b0, upd.a} + {1'b0, b_eff} + {8'h00, upd.is_sub};
    low_sum = {1'b0, upd.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, upd.is_sub};
    zero_flag = (upd.result == 8'h00);
    nibble_flag = low_sum[4];
    carry_flag = 1'b0;
    upd_nibble = 1'b0;
    upd_carry = 1'b0;
    case (upd.op)
      core_regs_pkg::ALU_ADDSUB:
      begin
        carry_flag = sum[8];
        upd_nibble = 1'b1;
        upd_carry = 1'b1;
      end
      core_regs_pkg::ALU_ROTATE:
      begin
        // bit leaving the source register
        carry_flag = upd.rot_left ? upd.a[7] : upd.a[0];
        upd_carry = 1'b1;
      end
      default:
      begin
        carry_flag = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> rtl/option_decode.sv
// option decoder: turns the option byte into timer, watchdog and port controls
`timescale 1ns/100ps
`default_nettype none
module option_decode
(
  input wire logic [7:0] option_byte,
  output var core_regs_pkg::option_ctl_t ctl
);
  logic [2:0] ratio;

  always_comb
  begin
    ratio = option_byte[core_regs_pkg::OPT_RATIO_LSB +: 3];
    ctl.pullup_disable = option_byte[core_regs_pkg::OPT_PULLUP_DIS];
    ctl.irq_rising = option_byte[core_regs_pkg::OPT_IRQ_EDGE];
    ctl.timer_external = option_byte[core_regs_pkg::OPT_TMR_SRC];
    ctl.timer_falling = option_byte[core_regs_pkg::OPT_TMR_EDGE];
    ctl.owner_watchdog = option_byte[core_regs_pkg::OPT_OWNER];
    // an unowned consumer sees divide by one; timer 2^(n+1), watchdog 2^n
    ctl.timer_div = ctl.owner_watchdog ? 9'h001 : (9'h002 << ratio);
    ctl.watchdog_div = ctl.owner_watchdog ? (8'h01 << ratio) : 8'h01;
  end
endmodule
`default_nettype wire

// >>> rtl/core_status_option_registers.sv
// core status and option register bank with flag update, reset-cause and bank logic
// Overview of operation
// - indirect page bit selects upper bank pair
// - bank bit maps direct addresses, 128-byte banks
// - power-down flag: set by power-up/kick, sleep clears
// - zero flag follows whether result is zero
// - nibble flag is carry from bit 3
// - carry flag is carry from msb
// - rotate loads carry with bit shifted out
// - subtract flags are inverted borrows
// - alu results beat software writes to flags
// - reset-cause flags ignore software writes
// - option register fully readable and writable
// - option bit 7 disables port pull-ups
// - edge select picks rising or falling interrupt
// - source select picks pin or instruction clock
// - timer edge select picks falling or rising
// - owner select gives prescaler to watchdog or timer
// - ratio divides timer 2^(n+1), watchdog 2^n
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module core_status_option_registers
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire core_regs_pkg::alu_update_t alu_upd,
  input wire logic kick_watchdog_insn,
  input wire logic sleep_insn,
  input wire logic watchdog_timeout,
  input wire logic [6:0] direct_addr,
  input wire logic [7:0] indirect_addr,
  output logic [8:0] direct_full_addr,
  output logic [8:0] indirect_full_addr,
  output var core_regs_pkg::option_ctl_t option_ctl,
  output logic [7:0] status_out
);
  logic [7:0] status_ff;
  logic [7:0] option_ff;
  logic [7:0] nxt_status;
  logic [7:0] nxt_option;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  logic st_hit;
  logic opt_hit;
  logic z_new;
  logic dc_new;
  logic c_new;
  logic upd_dc;
  logic upd_c;
  logic alu_act;

  alu_flag_calc u_flags
  (
    .upd(alu_upd),
    .zero_flag(z_new),
    .nibble_flag(dc_new),
    .carry_flag(c_new),
    .upd_nibble(upd_dc),
    .upd_carry(upd_c)
  );

  option_decode u_opt
  (
    .option_byte(option_ff),
    .ctl(option_ctl)
  );

  // status is visible in both banks, option only at its one offset
  assign st_hit = (reg_addr == core_regs_pkg::ALU_FLAGS_BANK_SELECT_OFF) ||
                  (reg_addr == core_regs_pkg::ALU_FLAGS_BANK_SELECT_MIR);
  assign opt_hit = (reg_addr == core_regs_pkg::PRESCALE_TIMER_CONFIG_OFF);
  assign alu_act = alu_upd.valid && (alu_upd.op != core_regs_pkg::ALU_NONE);

  // status next value: software write first, alu and events override
  always_comb
  begin
    nxt_status = status_ff;
    if (reg_wr && st_hit)
    begin
      // reset-cause bits keep their value whatever software writes
      nxt_status[core_regs_pkg::ST_CARRY] = reg_wdata[core_regs_pkg::ST_CARRY];
      nxt_status[core_regs_pkg::ST_NIBBLE] = reg_wdata[core_regs_pkg::ST_NIBBLE];
      nxt_status[core_regs_pkg::ST_ZERO] = reg_wdata[core_regs_pkg::ST_ZERO];
      nxt_status[core_regs_pkg::ST_BANK_LO] = reg_wdata[core_regs_pkg::ST_BANK_LO];
      nxt_status[core_regs_pkg::ST_BANK_HI] = reg_wdata[core_regs_pkg::ST_BANK_HI];
      nxt_status[core_regs_pkg::ST_IND_PAGE] = reg_wdata[core_regs_pkg::ST_IND_PAGE];
    end
    if (alu_act)
    begin
      // alu result wins over a write in the same cycle
      nxt_status[core_regs_pkg::ST_ZERO] = z_new;
      if (upd_dc)
      begin
        nxt_status[core_regs_pkg::ST_NIBBLE] = dc_new;
      end
      if (upd_c)
      begin
        nxt_status[core_regs_pkg::ST_CARRY] = c_new;
      end
    end
    // timeout clears expiry; kick or sleep set it, timeout given priority
    if (watchdog_timeout)
    begin
      nxt_status[core_regs_pkg::ST_TO] = 1'b0;
    end
    else if (kick_watchdog_insn || sleep_insn)
    begin
      nxt_status[core_regs_pkg::ST_TO] = 1'b1;
    end
    if (kick_watchdog_insn)
    begin
      nxt_status[core_regs_pkg::ST_PD] = 1'b1;
    end
    else if (sleep_insn)
    begin
      nxt_status[core_regs_pkg::ST_PD] = 1'b0;
    end
  end

  // status register; power-up value sets both reset-cause flags
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_ff <= core_regs_pkg::STATUS_RESET;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  // option register, plain read/write
  always_comb
  begin
    nxt_option = option_ff;
    if (reg_wr && opt_hit)
    begin
      nxt_option = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      option_ff <= core_regs_pkg::OPTION_RESET;
    end
    else
    begin
      option_ff <= nxt_option;
    end
  end

  // read data stand one cycle after the strobe; unmapped reads zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (reg_rd && st_hit)
    begin
      nxt_rdata = status_ff;
    end
    else if (reg_rd && opt_hit)
    begin
      nxt_rdata = option_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign status_out = status_ff;

  // bank mapping; upper bank bit stored but reserved, software keeps it zero
  always_comb
  begin
    direct_full_addr = {1'b0, direct_addr} +
      (status_ff[core_regs_pkg::ST_BANK_LO] ? core_regs_pkg::BANK_SPAN : 9'h000);
    indirect_full_addr = {1'b0, indirect_addr} |
      (status_ff[core_regs_pkg::ST_IND_PAGE] ? core_regs_pkg::IND_PAGE_BASE : 9'h000);
  end

  // sleep clears power-down on the next edge
  property p_sleep_pd;
    @(posedge mclk) disable iff (!rst_b)
    (sleep_insn && !kick_watchdog_insn) |=> !status_ff[core_regs_pkg::ST_PD];
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep did not clear power-down");

  property p_kick;
    @(posedge mclk) disable iff (!rst_b)
    (kick_watchdog_insn && !watchdog_timeout) |=>
      (status_ff[core_regs_pkg::ST_PD] && status_ff[core_regs_pkg::ST_TO]);
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not set reset-cause flags");

  property p_timeout;
    @(posedge mclk) disable iff (!rst_b)
    watchdog_timeout |=> !status_ff[core_regs_pkg::ST_TO];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not clear expiry");

  property p_zero;
    @(posedge mclk) disable iff (!rst_b)
    alu_act |=> (status_ff[core_regs_pkg::ST_ZERO] == ($past(alu_upd.result) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_add_carry;
    @(posedge mclk) disable iff (!rst_b)
    (alu_act && alu_upd.op == core_regs_pkg::ALU_ADDSUB && !alu_upd.is_sub) |=>
      (status_ff[core_regs_pkg::ST_CARRY] ==
        ((9'({1'b0, $past(alu_upd.a)}) + 9'({1'b0, $past(alu_upd.b)})) > 9'h0ff));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_sub_borrow;
    @(posedge mclk) disable iff (!rst_b)
    (alu_act && alu_upd.op == core_regs_pkg::ALU_ADDSUB && alu_upd.is_sub) |=>
      (status_ff[core_regs_pkg::ST_CARRY] == ($past(alu_upd.a) >= $past(alu_upd.b)));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

  property p_nibble;
    @(posedge mclk) disable iff (!rst_b)
    (alu_act && alu_upd.op == core_regs_pkg::ALU_ADDSUB && !alu_upd.is_sub) |=>
      (status_ff[core_regs_pkg::ST_NIBBLE] ==
        ((5'($past(alu_upd.a[3:0])) + 5'($past(alu_upd.b[3:0]))) > 5'h0f));
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble flag wrong");

  property p_rotate;
    @(posedge mclk) disable iff (!rst_b)
    (alu_act && alu_upd.op == core_regs_pkg::ALU_ROTATE) |=>
      (status_ff[core_regs_pkg::ST_CARRY] ==
        ($past(alu_upd.rot_left) ? $past(alu_upd.a[7]) : $past(alu_upd.a[0])));
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

  property p_write_cause;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && st_hit && !kick_watchdog_insn && !sleep_insn && !watchdog_timeout) |=>
      $stable(status_ff[core_regs_pkg::ST_TO]) && $stable(status_ff[core_regs_pkg::ST_PD]);
  endproperty
  a_write_cause: assert property (p_write_cause) else $error("software changed reset cause");

  property p_option_rw;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) ##1 (reg_rd && opt_hit) |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_option_rw: assert property (p_option_rw) else $error("option readback wrong");

  property p_pullup;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) |=>
      (option_ctl.pullup_disable == $past(reg_wdata[core_regs_pkg::OPT_PULLUP_DIS]));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up control mismatch");

  // built by concatenation so the adder in the mapping is checked independently
  property p_bank;
    @(posedge mclk) disable iff (!rst_b)
    direct_full_addr == {1'b0, status_ff[core_regs_pkg::ST_BANK_LO], direct_addr};
  endproperty
  a_bank: assert property (p_bank) else $error("direct bank mapping wrong");

  property p_ind_page;
    @(posedge mclk) disable iff (!rst_b)
    indirect_full_addr == {status_ff[core_regs_pkg::ST_IND_PAGE], indirect_addr};
  endproperty
  a_ind_page: assert property (p_ind_page) else $error("indirect page mapping wrong");

  // bank bits always follow a status write
  property p_write_bank;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && st_hit) |=>
      (status_ff[core_regs_pkg::ST_IND_PAGE:core_regs_pkg::ST_BANK_LO] ==
        $past(reg_wdata[core_regs_pkg::ST_IND_PAGE:core_regs_pkg::ST_BANK_LO]));
  endproperty
  a_write_bank: assert property (p_write_bank) else $error("bank bits not written");

  // with no alu operation the written flags land as they are
  property p_write_flags;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && st_hit && !alu_act) |=>
      (status_ff[core_regs_pkg::ST_ZERO:core_regs_pkg::ST_CARRY] ==
        $past(reg_wdata[core_regs_pkg::ST_ZERO:core_regs_pkg::ST_CARRY]));
  endproperty
  a_write_flags: assert property (p_write_flags) else $error("flag write lost");

  // an add beside a write: zero comes from the result, not from the data
  property p_flag_override;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && st_hit && alu_act && alu_upd.op == core_regs_pkg::ALU_ADDSUB) |=>
      (status_ff[core_regs_pkg::ST_ZERO] == ($past(alu_upd.result) == 8'h00));
  endproperty
  a_flag_override: assert property (p_flag_override) else $error("write beat alu");

  property p_option_write;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) |=> (option_ff == $past(reg_wdata));
  endproperty
  a_option_write: assert property (p_option_write) else $error("option write lost");

  property p_irq_edge;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) |=>
      (option_ctl.irq_rising == $past(reg_wdata[core_regs_pkg::OPT_IRQ_EDGE]));
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("interrupt edge control wrong");

  property p_tmr_src;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) |=>
      (option_ctl.timer_external == $past(reg_wdata[core_regs_pkg::OPT_TMR_SRC]));
  endproperty
  a_tmr_src: assert property (p_tmr_src) else $error("timer source control wrong");

  property p_tmr_edge;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) |=>
      (option_ctl.timer_falling == $past(reg_wdata[core_regs_pkg::OPT_TMR_EDGE]));
  endproperty
  a_tmr_edge: assert property (p_tmr_edge) else $error("timer edge control wrong");

  property p_owner;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit) |=>
      (option_ctl.owner_watchdog == $past(reg_wdata[core_regs_pkg::OPT_OWNER]));
  endproperty
  a_owner: assert property (p_owner) else $error("prescaler owner wrong");

  // one-hot plus right shift, so the shifter in the decoder is not mirrored here
  property p_timer_div;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit && !reg_wdata[core_regs_pkg::OPT_OWNER]) |=>
      ($onehot(option_ctl.timer_div) && (option_ctl.watchdog_div == 8'h01) &&
        ((option_ctl.timer_div >> $past(reg_wdata[core_regs_pkg::OPT_RATIO_LSB +: 3])) ==
          9'h002));
  endproperty
  a_timer_div: assert property (p_timer_div) else $error("timer ratio wrong");

  property p_wdog_div;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && opt_hit && reg_wdata[core_regs_pkg::OPT_OWNER]) |=>
      ($onehot(option_ctl.watchdog_div) && (option_ctl.timer_div == 9'h001) &&
        ((option_ctl.watchdog_div >> $past(reg_wdata[core_regs_pkg::OPT_RATIO_LSB +: 3])) ==
          8'h01));
  endproperty
  a_wdog_div: assert property (p_wdog_div) else $error("watchdog ratio wrong");

endmodule
`default_nettype wire

// >>> test/core_model.sv
// core model: drives alu flag updates and reset-cause events into the register bank
`timescale 1ns/100ps
`default_nettype none
module core_model
(
  input wire logic mclk,
  output var core_regs_pkg::alu_update_t alu_upd,
  output logic kick_watchdog_insn,
  output logic sleep_insn,
  output logic watchdog_timeout
);
  initial
  begin
    alu_upd = '0;
    kick_watchdog_insn = 1'h0;
    sleep_insn = 1'h0;
    watchdog_timeout = 1'h0;
  end

  // one operation for one cycle; the payload stays behind with valid low,
  // so a bank that ignores valid shows up at once
  task automatic alu(input core_regs_pkg::alu_class_t op, input logic sub, input logic left,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] r);
  begin
    @(posedge mclk);
    alu_upd.valid <= 1'h1;
    alu_upd.op <= op;
    alu_upd.is_sub <= sub;
    alu_upd.rot_left <= left;
    alu_upd.a <= a;
    alu_upd.b <= b;
    alu_upd.result <= r;
    @(posedge mclk);
    alu_upd.valid <= 1'h0;
  end
  endtask

  // one-cycle event pulse: 0 kick, 1 sleep, 2 timeout
  task automatic ev(input int which);
  begin
    @(posedge mclk);
    kick_watchdog_insn <= (which == 0);
    sleep_insn <= (which == 1);
    watchdog_timeout <= (which == 2);
    @(posedge mclk);
    kick_watchdog_insn <= 1'h0;
    sleep_insn <= 1'h0;
    watchdog_timeout <= 1'h0;
  end
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// testbench: register access, reset-cause events, alu flags and option decode
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [6:0] direct_addr;
  logic [7:0] indirect_addr;
  logic [8:0] direct_full_addr;
  logic [8:0] indirect_full_addr;
  logic [7:0] status_out;
  logic kick;
  logic sleep;
  logic tmo;
  core_regs_pkg::alu_update_t alu_upd;
  core_regs_pkg::option_ctl_t option_ctl;
  core_regs_pkg::option_ctl_t e;
  logic [7:0] v;
  logic [30:0] t;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  // divide ratios per field value: timer 1:2 up to 1:256, watchdog 1:1 up to 1:128
  logic [8:0] tmr_ratio [8] = '{9'h002, 9'h004, 9'h008, 9'h010,
    9'h020, 9'h040, 9'h080, 9'h100};
  logic [7:0] wdt_ratio [8] = '{8'h01, 8'h02, 8'h04, 8'h08,
    8'h10, 8'h20, 8'h40, 8'h80};
  // op, sub, left, a, b, result, expected zero/nibble/carry
  logic [30:0] tbl [8] = '{
    {2'h2, 1'h0, 1'h0, 8'hff, 8'h01, 8'h00, 3'h7},
    {2'h2, 1'h0, 1'h0, 8'h08, 8'h08, 8'h10, 3'h2},
    {2'h2, 1'h1, 1'h0, 8'h05, 8'h03, 8'h02, 3'h3},
    {2'h2, 1'h1, 1'h0, 8'h03, 8'h05, 8'hfe, 3'h0},
    {2'h3, 1'h0, 1'h1, 8'h81, 8'h00, 8'h03, 3'h1},
    {2'h3, 1'h0, 1'h0, 8'h02, 8'h00, 8'h01, 3'h0},
    {2'h1, 1'h0, 1'h0, 8'hf0, 8'h0f, 8'h00, 3'h4},
    {2'h2, 1'h1, 1'h0, 8'h10, 8'h01, 8'h0f, 3'h1}};

  core_status_option_registers dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alu_upd(alu_upd), .kick_watchdog_insn(kick), .sleep_insn(sleep),
    .watchdog_timeout(tmo), .direct_addr(direct_addr), .indirect_addr(indirect_addr),
    .direct_full_addr(direct_full_addr), .indirect_full_addr(indirect_full_addr),
    .option_ctl(option_ctl), .status_out(status_out));
  core_model core (.mclk(mclk), .alu_upd(alu_upd), .kick_watchdog_insn(kick),
    .sleep_insn(sleep), .watchdog_timeout(tmo));

  initial
  begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // one-cycle write strobe, then wait to mid-cycle so register updates have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    @(negedge mclk);
  end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  end
  endtask

  // write then read back with no idle cycle between the two strobes
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    chk(reg_rdata, d);
  end
  endtask

  task automatic evchk(input int which, input logic [7:0] exp);
  begin
    core.ev(which);
    @(negedge mclk);
    chk(status_out, exp);
  end
  endtask

  task automatic end_sim;
  begin
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // hang guard; the whole run needs about 120 cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_fail++;
      end_sim;
    end
  end

  initial
  begin
    rst_b = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    direct_addr = 7'h12;
    indirect_addr = 8'h34;
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
    @(negedge mclk);
    chk(status_out, 8'h18);
    rd(8'h03, 8'h18);
    rd(8'h81, 8'hff);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h81, 8'hff);
    $display("test reset_and_map done");
    wr(8'h03, 8'he7);
    chk(status_out, 8'hff);
    chk(direct_full_addr, 9'h092);
    chk(indirect_full_addr, 9'h134);
    evchk(1, 8'hf7);
    evchk(2, 8'he7);
    // move the address inputs so the mapping is seen at other values too
    @(posedge mclk);
    direct_addr <= 7'h7f;
    indirect_addr <= 8'hcd;
    wr(8'h83, 8'h18);
    chk(status_out, 8'h00);
    chk(direct_full_addr, 9'h07f);
    chk(indirect_full_addr, 9'h0cd);
    evchk(1, 8'h10);
    evchk(0, 8'h18);
    rd(8'h83, 8'h18);
    $display("test bank_and_reset_cause done");
    for (int i = 0; i < 8; i++)
    begin
      t = tbl[i];
      core.alu(core_regs_pkg::alu_class_t'(t[30:29]), t[28], t[27], t[26:19], t[18:11],
        t[10:3]);
      @(negedge mclk);
      chk(status_out, {5'h03, t[2:0]});
    end
    // a software write and a flag update in the same cycle
    fork
      wr(8'h03, 8'h07);
      core.alu(core_regs_pkg::ALU_ADDSUB, 1'h0, 1'h0, 8'h01, 8'h01, 8'h02);
    join
    chk(status_out, 8'h18);
    $display("test alu_flags done");
    for (int i = 0; i < 16; i++)
    begin
      v = {i[0], i[1], i[2], i[3], i[3:0]};
      wr(8'h81, v);
      e.pullup_disable = v[7];
      e.irq_rising = v[6];
      e.timer_external = v[5];
      e.timer_falling = v[4];
      e.owner_watchdog = v[3];
      e.timer_div = v[3] ? 9'h001 : tmr_ratio[v[2:0]];
      e.watchdog_div = v[3] ? wdt_ratio[v[2:0]] : 8'h01;
      chk(option_ctl, e);
      rd(8'h81, v);
    end
    wrrd(8'h81, 8'ha5);
    wrrd(8'h81, 8'h3c);
    $display("test option_decode done");
    end_sim;
  end
endmodule
`default_nettype wire
